// ### ecu_defines.vh
`ifndef ECU_DEFINES_VH
`define ECU_DEFINES_VH

// Bus map, byte addresses
`define ECU_ADDR_CTRL 12'h000
`define ECU_ADDR_SLOT 12'h004
`define ECU_ADDR_STATUS 12'h008
`define ECU_CHREG_SEL 2'h1

// Control and status fields
`define ECU_CTRL_START 0
`define ECU_CTRL_SHARED 1
`define ECU_STAT_BUSY 0
`define ECU_STAT_DONE 1

// Image layout
`define ECU_SET_BYTES 74
`define ECU_FIRST_SLOT 10'h033
`define ECU_LAST_OFFSET 5'h18

// Channel register numbers held by this block
`define ECU_CR_BOOST 6'h03
`define ECU_CR_CAP0 6'h08
`define ECU_CR_OVR_A 6'h09
`define ECU_CR_OVR_B 6'h0a
`define ECU_CR_CAP1 6'h0b
`define ECU_CR_TMR_A 6'h0e
`define ECU_CR_TMR_B 6'h0f
`define ECU_CR_THR 6'h10
`define ECU_CR_PDIQ 6'h18
`define ECU_CR_BGAP 6'h19
`define ECU_CR_TAP54 6'h20
`define ECU_CR_TAP32 6'h21
`define ECU_CR_SWING 6'h2d

// Reset value of every held channel register
`define ECU_CR_RST 8'h00

`endif

// ### ecu_unpacker.v
`timescale 1ns/10ps
`include "ecu_defines.vh"

// What this block does
// - Image byte 0 copies unchanged into channel register 0x03.
// - Register 0x03 holds four two-bit boost stage settings, stage 0 on top.
// - Byte 1 bits 7:3 load register 0x08 bits 4:0.
// - Byte 1 bits 2,1,0 load register 0x09 bits 7,6,5.
// - Byte 3 bits 7:3 load register 0x0a bits 4:0.
// - Byte 3 bits 2:0 load register 0x0b bits 4:2.
// - Byte 4 bits 7:6 load register 0x0b bits 1:0.
// - Each offset reads a distinct EEPROM address from slot start and channel.
// - Byte 2 bits 7:3 load 0x09 bits 4:0, bits 2:0 load 0x0a bits 7:5.
// - Register 0x0e bits 7:0 come from byte 4 bits 3:0 and byte 5 bits 7:4.
// - Register 0x0f bits 7:0 come from byte 5 bits 3:0 and byte 6 bits 7:4.
// - Register 0x10 bits 7:0 come from byte 6 bits 3:0 and byte 7 bits 7:4.
// - Bytes 0x12 and 0x13 copy into registers 0x20 and 0x21.
// - Register 0x2d bits 7:0 come from byte 0x17 bits 6:0 and 0x18 bit 7.
// - Byte 0x0e loads 0x18 bits 5:4 and 0x19 bits 5:0.
// - Each channel set is 74 bytes; channel n starts 74*n past slot start.
// - Shared image mode uses one set for all channels, else four sets.
// - Sequential register bits come from sequential image bits in order.
module ecu_unpacker #(
  parameter AW = 10,
  parameter NCH = 4
) (
  input wire MCLK, // Core clock, 20 MHz
  input wire RSTN, // Synchronous reset, active low
  input wire [11:0] PADDR, // APB address
  input wire PSEL, // APB select
  input wire PENABLE, // APB access phase
  input wire PWRITE, // APB direction
  input wire [31:0] PWDATA, // APB write data
  output reg [31:0] PRDATA, // APB read data
  output reg PREADY, // APB ready
  output reg PSLVERR, // APB error
  output reg EE_REQ, // EEPROM byte read request, held until ack
  output reg [AW-1:0] EE_ADDR, // EEPROM byte address
  input wire EE_ACK, // One-cycle pulse, EE_DATA valid
  input wire [7:0] EE_DATA, // EEPROM byte
  output reg LOAD_DONE, // Image load finished
  output reg [NCH*13*8-1:0] CH_REGS // Held channel registers, flat
);

  localparam NREG = 13;
  localparam S_IDLE = 2'd0;
  localparam S_FETCH = 2'd1;
  localparam S_APPLY = 2'd2;
  localparam [AW-1:0] SET_BYTES = `ECU_SET_BYTES;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] off_reg;
  reg [1:0] chan_reg;
  reg [AW-1:0] set_base_reg;
  reg [AW-1:0] slot_reg;
  reg shared_channel_image;
  reg [7:0] byte_reg;
  reg busy_reg;
  reg [NCH*13*8-1:0] regs_next;
  reg wa_en;
  reg [3:0] wa_idx;
  reg [7:0] wa_mask;
  reg [7:0] wa_dat;
  reg wb_en;
  reg [3:0] wb_idx;
  reg [7:0] wb_mask;
  reg [7:0] wb_dat;
  reg [3:0] rd_idx;
  reg [7:0] rd_byte;
  integer ch;

  wire apb_acc = PSEL && PENABLE && !PREADY;
  wire apb_wr = apb_acc && PWRITE;
  wire chreg_win = (PADDR[11:10] == `ECU_CHREG_SEL);
  wire start_req = apb_wr && (PADDR == `ECU_ADDR_CTRL) && PWDATA[`ECU_CTRL_START] && !busy_reg;
  wire last_off = (off_reg == `ECU_LAST_OFFSET);
  wire last_chan = shared_channel_image || (chan_reg == NCH - 1);

  // Offset-to-bit decode of one image byte into up to two masked writes
  always @* begin
    wa_en = 1'b0;
    wa_idx = 4'd0;
    wa_mask = 8'h00;
    wa_dat = 8'h00;
    wb_en = 1'b0;
    wb_idx = 4'd0;
    wb_mask = 8'h00;
    wb_dat = 8'h00;
    case (off_reg)
      // boost stages 7:6 down to 1:0
      5'h00: begin
        wa_en = 1'b1;
        wa_mask = 8'hff;
        wa_dat = byte_reg;
      end
      5'h01: begin
        wa_en = 1'b1;
        wa_idx = 4'd1;
        wa_mask = 8'h1f;
        wa_dat = {3'b000, byte_reg[7:3]};
        wb_en = 1'b1;
        wb_idx = 4'd2;
        wb_mask = 8'he0;
        wb_dat = {byte_reg[2:0], 5'b00000};
      end
      5'h02: begin
        wa_en = 1'b1;
        wa_idx = 4'd2;
        wa_mask = 8'h1f;
        wa_dat = {3'b000, byte_reg[7:3]};
        wb_en = 1'b1;
        wb_idx = 4'd3;
        wb_mask = 8'he0;
        wb_dat = {byte_reg[2:0], 5'b00000};
      end
      5'h03: begin
        wa_en = 1'b1;
        wa_idx = 4'd3;
        wa_mask = 8'h1f;
        wa_dat = {3'b000, byte_reg[7:3]};
        wb_en = 1'b1;
        wb_idx = 4'd4;
        wb_mask = 8'h1c;
        wb_dat = {3'b000, byte_reg[2:0], 2'b00};
      end
      5'h04: begin
        wa_en = 1'b1;
        wa_idx = 4'd4;
        wa_mask = 8'h03;
        wa_dat = {6'b000000, byte_reg[7:6]};
        wb_en = 1'b1;
        wb_idx = 4'd5;
        wb_mask = 8'hf0;
        wb_dat = {byte_reg[3:0], 4'b0000};
      end
      5'h05: begin
        wa_en = 1'b1;
        wa_idx = 4'd5;
        wa_mask = 8'h0f;
        wa_dat = {4'b0000, byte_reg[7:4]};
        wb_en = 1'b1;
        wb_idx = 4'd6;
        wb_mask = 8'hf0;
        wb_dat = {byte_reg[3:0], 4'b0000};
      end
      5'h06: begin
        wa_en = 1'b1;
        wa_idx = 4'd6;
        wa_mask = 8'h0f;
        wa_dat = {4'b0000, byte_reg[7:4]};
        wb_en = 1'b1;
        wb_idx = 4'd7;
        wb_mask = 8'hf0;
        wb_dat = {byte_reg[3:0], 4'b0000};
      end
      5'h07: begin
        wa_en = 1'b1;
        wa_idx = 4'd7;
        wa_mask = 8'h0f;
        wa_dat = {4'b0000, byte_reg[7:4]};
      end
      // divider top bit ahead of byte 0x0e
      5'h0d: begin
        wa_en = 1'b1;
        wa_idx = 4'd8;
        wa_mask = 8'h40;
        wa_dat = {1'b0, byte_reg[0], 6'b000000};
      end
      5'h0e: begin
        wa_en = 1'b1;
        wa_idx = 4'd8;
        wa_mask = 8'h30;
        wa_dat = {2'b00, byte_reg[7:6], 4'b0000};
        wb_en = 1'b1;
        wb_idx = 4'd9;
        wb_mask = 8'h3f;
        wb_dat = {2'b00, byte_reg[5:0]};
      end
      5'h12: begin
        wa_en = 1'b1;
        wa_idx = 4'd10;
        wa_mask = 8'hff;
        wa_dat = byte_reg;
      end
      5'h13: begin
        wa_en = 1'b1;
        wa_idx = 4'd11;
        wa_mask = 8'hff;
        wa_dat = byte_reg;
      end
      5'h17: begin
        wa_en = 1'b1;
        wa_idx = 4'd12;
        wa_mask = 8'hfe;
        wa_dat = {byte_reg[6:0], 1'b0};
      end
      5'h18: begin
        wa_en = 1'b1;
        wa_idx = 4'd12;
        wa_mask = 8'h01;
        wa_dat = {7'b0000000, byte_reg[7]};
      end
      default: begin
        wa_en = 1'b0;
      end
    endcase
  end

  // masked merge into the targeted channels
  always @* begin
    regs_next = CH_REGS;
    if (state_reg == S_APPLY) begin
      for (ch = 0; ch < NCH; ch = ch + 1) begin
        if (shared_channel_image || (ch == chan_reg)) begin
          if (wa_en) begin
            regs_next[(ch*NREG+wa_idx)*8 +: 8] =
              (CH_REGS[(ch*NREG+wa_idx)*8 +: 8] & ~wa_mask) | (wa_dat & wa_mask);
          end
          if (wb_en) begin
            regs_next[(ch*NREG+wb_idx)*8 +: 8] =
              (CH_REGS[(ch*NREG+wb_idx)*8 +: 8] & ~wb_mask) | (wb_dat & wb_mask);
          end
        end
      end
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_req) begin
          state_next = S_FETCH;
        end
      end
      S_FETCH: begin
        if (EE_ACK) begin
          state_next = S_APPLY;
        end
      end
      S_APPLY: begin
        if (last_off && last_chan) begin
          state_next = S_IDLE;
        end else begin
          state_next = S_FETCH;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (!RSTN) begin
      state_reg <= S_IDLE;
      off_reg <= 5'h00;
      chan_reg <= 2'd0;
      set_base_reg <= {AW{1'b0}};
      byte_reg <= 8'h00;
      busy_reg <= 1'b0;
      EE_REQ <= 1'b0;
      EE_ADDR <= {AW{1'b0}};
      LOAD_DONE <= 1'b0;
      // untargeted bits start and stay at reset
      CH_REGS <= {(NCH*NREG){`ECU_CR_RST}};
    end else begin
      state_reg <= state_next;
      CH_REGS <= regs_next;
      if (start_req) begin
        off_reg <= 5'h00;
        chan_reg <= 2'd0;
        set_base_reg <= slot_reg;
        busy_reg <= 1'b1;
        LOAD_DONE <= 1'b0;
        EE_REQ <= 1'b1;
        EE_ADDR <= slot_reg;
      end
      if (state_reg == S_FETCH && EE_ACK) begin
        byte_reg <= EE_DATA;
        EE_REQ <= 1'b0;
      end
      if (state_reg == S_APPLY) begin
        if (last_off) begin
          if (last_chan) begin
            busy_reg <= 1'b0;
            LOAD_DONE <= 1'b1;
          end else begin
            // next set lies 74 bytes on
            chan_reg <= chan_reg + 2'd1;
            off_reg <= 5'h00;
            set_base_reg <= set_base_reg + SET_BYTES;
            EE_REQ <= 1'b1;
            EE_ADDR <= set_base_reg + SET_BYTES;
          end
        end else begin
          // address from slot, channel and offset
          off_reg <= off_reg + 5'h01;
          EE_REQ <= 1'b1;
          EE_ADDR <= set_base_reg + {{(AW-5){1'b0}}, off_reg + 5'h01};
        end
      end
    end
  end

  // Channel register number to storage index
  always @* begin
    case (PADDR[7:2])
      `ECU_CR_BOOST: rd_idx = 4'd0;
      `ECU_CR_CAP0: rd_idx = 4'd1;
      `ECU_CR_OVR_A: rd_idx = 4'd2;
      `ECU_CR_OVR_B: rd_idx = 4'd3;
      `ECU_CR_CAP1: rd_idx = 4'd4;
      `ECU_CR_TMR_A: rd_idx = 4'd5;
      `ECU_CR_TMR_B: rd_idx = 4'd6;
      `ECU_CR_THR: rd_idx = 4'd7;
      `ECU_CR_PDIQ: rd_idx = 4'd8;
      `ECU_CR_BGAP: rd_idx = 4'd9;
      `ECU_CR_TAP54: rd_idx = 4'd10;
      `ECU_CR_TAP32: rd_idx = 4'd11;
      `ECU_CR_SWING: rd_idx = 4'd12;
      default: rd_idx = 4'd15;
    endcase
    rd_byte = 8'h00;
    if (rd_idx != 4'd15 && PADDR[9:8] < NCH) begin
      rd_byte = CH_REGS[(PADDR[9:8]*NREG+rd_idx)*8 +: 8];
    end
  end

  // APB slave, one wait state on every access
  always @(posedge MCLK) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      slot_reg <= `ECU_FIRST_SLOT;
      shared_channel_image <= 1'b0;
    end else begin
      PREADY <= apb_acc;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (apb_acc) begin
        if (PWRITE) begin
          if (PADDR == `ECU_ADDR_CTRL) begin
            if (!busy_reg) begin
              shared_channel_image <= PWDATA[`ECU_CTRL_SHARED];
            end
          end else if (PADDR == `ECU_ADDR_SLOT) begin
            if (!busy_reg) begin
              slot_reg <= PWDATA[AW-1:0];
            end
          end else begin
            PSLVERR <= 1'b1;
          end
        end else begin
          if (PADDR == `ECU_ADDR_CTRL) begin
            PRDATA[`ECU_CTRL_SHARED] <= shared_channel_image;
          end else if (PADDR == `ECU_ADDR_SLOT) begin
            PRDATA[AW-1:0] <= slot_reg;
          end else if (PADDR == `ECU_ADDR_STATUS) begin
            PRDATA[`ECU_STAT_BUSY] <= busy_reg;
            PRDATA[`ECU_STAT_DONE] <= LOAD_DONE;
          end else if (chreg_win && rd_idx != 4'd15 && PADDR[9:8] < NCH) begin
            PRDATA[7:0] <= rd_byte;
          end else begin
            PSLVERR <= 1'b1;
          end
        end
      end
    end
  end

endmodule // ecu_unpacker

// ### ecu_unpacker_sva.sv
`timescale 1ns/10ps
module ecu_unpacker_chk #(
  parameter AW = 10,
  parameter NCH = 4
) (
  input wire MCLK, // Clock
  input wire RSTN, // Reset, low
  input wire PSEL, // Select
  input wire PENABLE, // Access
  input wire PREADY, // Ready
  input wire PSLVERR, // Error
  input wire [31:0] PRDATA, // Read data
  input wire EE_REQ, // Byte request
  input wire [AW-1:0] EE_ADDR, // Byte address
  input wire EE_ACK, // Byte answer
  input wire LOAD_DONE, // Load finished
  input wire [NCH*13*8-1:0] CH_REGS // Channel registers
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  sequence s_take;
    EE_REQ && EE_ACK;
  endsequence
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  AST_EE_HOLD: assert property (
    EE_REQ && !EE_ACK |=> EE_REQ && $stable(EE_ADDR))
    else $error("request dropped or address moved");
  AST_EE_NEXT: assert property (
    s_take |=> !EE_REQ ##1 (EE_REQ || LOAD_DONE))
    else $error("next byte request not two cycles after answer");
  AST_ADDR_STEP: assert property (
    s_take ##2 EE_REQ |-> EE_ADDR == $past(EE_ADDR, 2) + 10'h001 || EE_ADDR == $past(EE_ADDR, 2) + 10'h032)
    else $error("byte address step wrong");
  AST_APB_WAIT: assert property (s_wait |=> PREADY)
    else $error("ready not after one wait state");
  AST_READY_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  AST_ERR_QUAL: assert property (PSLVERR |-> PREADY && PSEL)
    else $error("error outside ready");
  AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data not zero when idle");
  AST_REGS_HOLD: assert property (
    LOAD_DONE ##1 LOAD_DONE |-> $stable(CH_REGS))
    else $error("channel registers moved after load");
  AST_REGS_CAUSE: assert property (
    $changed(CH_REGS) |-> $past(EE_ACK) || $past(EE_ACK, 2))
    else $error("channel registers changed without a byte");
endmodule // ecu_unpacker_chk

bind ecu_unpacker ecu_unpacker_chk #(.AW(AW), .NCH(NCH)) u_chk (
  .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PRDATA(PRDATA), .EE_REQ(EE_REQ), .EE_ADDR(EE_ADDR),
  .EE_ACK(EE_ACK), .LOAD_DONE(LOAD_DONE), .CH_REGS(CH_REGS));

// ### ecu_eeprom_model.sv
`timescale 1ns/10ps
module ecu_eeprom_model (
  input wire clk, // Core clock
  input wire rstn, // Reset, low
  input wire req, // Byte request
  input wire [9:0] addr, // Byte address
  output reg ack, // One-cycle answer
  output reg [7:0] data // Byte
);
  reg [7:0] mem [0:1023];
  reg [1:0] cnt_reg;
  // Latency of one to four cycles; data scrambled when not answering
  always @(posedge clk) begin
    if (!rstn) begin
      ack <= 1'b0;
      cnt_reg <= 2'h0;
      data <= 8'h00;
    end else if (req && !ack && cnt_reg == addr[1:0]) begin
      ack <= 1'b1;
      data <= mem[addr];
      cnt_reg <= 2'h0;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      cnt_reg <= (req && !ack) ? cnt_reg + 2'h1 : 2'h0;
    end
  end
endmodule // ecu_eeprom_model

// ### tb_ecu_unpacker.sv
`timescale 1ns/10ps
`include "ecu_defines.vh"
module tb_ecu_unpacker;
  typedef struct {string nm; logic [32:0] v;} ecu_exp_t;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ee_req, ee_ack, load_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] ee_addr;
  logic [7:0] ee_data;
  logic [415:0] ch_regs;
  logic [7:0] img [0:1023];
  bit [7:0] rn [13] = '{8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h10, 8'h18, 8'h19, 8'h20, 8'h21, 8'h2d};
  ecu_exp_t exp_q[$];
  ecu_exp_t cur;
  integer seed, n_mismatch, samples_checked, s1, s2;

  ecu_unpacker #(.AW(10), .NCH(4)) uut (
    .MCLK(mclk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EE_REQ(ee_req),
    .EE_ADDR(ee_addr), .EE_ACK(ee_ack), .EE_DATA(ee_data), .LOAD_DONE(load_done), .CH_REGS(ch_regs));
  ecu_eeprom_model ee (.clk(mclk), .rstn(rstn), .req(ee_req), .addr(ee_addr), .ack(ee_ack), .data(ee_data));

  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end

  task print_verdict;
    begin
      $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  task apb(input bit w, input [11:0] a, input [31:0] d, input [32:0] e, input string nm);
    integer n;
    begin
      exp_q.push_back('{nm, e});
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
        n_mismatch++;
        print_verdict;
      end
      @(posedge mclk);
    end
  endtask

  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("unexpected answer: expected none, seen %h", prdata);
      end else begin
        cur = exp_q.pop_front();
        samples_checked++;
        if ({pslverr, prdata} !== cur.v) begin
          n_mismatch++;
          $display("unexpected %s: expected %h, seen %h", cur.nm, cur.v, {pslverr, prdata});
        end
      end
    end
  end

  function automatic [7:0] ex(input integer b, input [7:0] r);
    case (r)
      8'h03: ex = img[b];
      8'h08: ex = img[b+1] >> 3;
      8'h09: ex = {img[b+1][2:0], img[b+2][7:3]};
      8'h0a: ex = {img[b+2][2:0], img[b+3][7:3]};
      8'h0b: ex = {img[b+3][2:0], img[b+4][7:6]};
      8'h0e: ex = {img[b+4][3:0], img[b+5][7:4]};
      8'h0f: ex = {img[b+5][3:0], img[b+6][7:4]};
      8'h10: ex = {img[b+6][3:0], img[b+7][7:4]};
      8'h18: ex = {img[b+13][0], img[b+14][7:6], 4'h0};
      8'h19: ex = img[b+14][5:0];
      8'h20: ex = img[b+18];
      8'h21: ex = img[b+19];
      default: ex = {img[b+23][6:0], img[b+24][7]};
    endcase
  endfunction

  task check_all(input integer slot, input bit sh);
    integer c, k;
    logic [7:0] want;
    begin
      for (c = 0; c < 4; c++) begin
        for (k = 0; k < 13; k++) begin
          want = ex(slot + 74 * (sh ? 0 : c), rn[k]);
          samples_checked++;
          if (ch_regs[(c * 13 + k) * 8 +: 8] !== want) begin
            n_mismatch++;
            $display("unexpected ch_regs: expected %h, seen %h", want, ch_regs[(c * 13 + k) * 8 +: 8]);
          end
          apb(0, 12'(12'h400 + c * 256 + rn[k] * 4), 0, {25'h0, want}, "chan_reg");
        end
      end
    end
  endtask

  task wait_done;
    integer n;
    begin
      n = 0;
      while (load_done !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      if (load_done !== 1'b1) begin
        n_mismatch++;
        print_verdict;
      end
    end
  endtask

  initial begin
    seed = 32'h61ec;
    n_mismatch = 0;
    samples_checked = 0;
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    for (int i = 0; i < 1024; i++) begin
      img[i] = $random(seed);
      ee.mem[i] = img[i];
    end
    s1 = {$random(seed)} % 700;
    s2 = {$random(seed)} % 700;
    repeat (6) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    apb(0, `ECU_ADDR_SLOT, 0, 33'h33, "slot");
    apb(0, `ECU_ADDR_STATUS, 0, 33'h0, "status");
    apb(0, 12'h4b4, 0, 33'h0, "chan_reg");
    apb(0, 12'h00c, 0, 33'h1_0000_0000, "unmapped");
    apb(1, `ECU_ADDR_STATUS, 1, 33'h1_0000_0000, "ro_write");
    apb(1, `ECU_ADDR_SLOT, s1, 0, "slot");
    apb(1, `ECU_ADDR_CTRL, 1, 0, "start");
    apb(0, `ECU_ADDR_STATUS, 0, 33'h1, "status");
    apb(1, `ECU_ADDR_CTRL, 3, 0, "start");
    apb(1, 12'h40c, 5, 33'h1_0000_0000, "ch_write");
    apb(1, `ECU_ADDR_SLOT, s2, 0, "slot");
    apb(0, `ECU_ADDR_SLOT, 0, s1, "slot");
    wait_done;
    apb(0, `ECU_ADDR_STATUS, 0, 33'h2, "status");
    apb(0, `ECU_ADDR_CTRL, 0, 33'h0, "ctrl");
    check_all(s1, 0);
    apb(1, `ECU_ADDR_CTRL, 2, 0, "ctrl");
    apb(0, `ECU_ADDR_CTRL, 0, 33'h2, "ctrl");
    apb(1, `ECU_ADDR_SLOT, s2, 0, "slot");
    apb(1, `ECU_ADDR_CTRL, 3, 0, "start");
    wait_done;
    check_all(s2, 1);
    print_verdict;
  end
endmodule // tb_ecu_unpacker
